// ---- logic/rclk_pkg.sv ----
// Purpose: Shared constants and types for the recovered clock one output block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, word aligned
// Notes:   Source ticks mark half periods of a nominal 125 MHz reference
package rclk_pkg;

	localparam int          NUM_PORTS = 4;
	localparam int          NUM_PATHS = 3;
	localparam int          ADDR_W    = 8;
	localparam int          DATA_W    = 32;
	localparam int          CTRL_W    = 16;

	// Register indices and byte addresses
	localparam logic [7:0]  CTRL_INDEX    = 8'h17;
	localparam logic [7:0]  STATUS_INDEX  = 8'h20;
	localparam logic [ADDR_W-1:0] CTRL_ADDR   = ADDR_W'(CTRL_INDEX * 4);
	localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'(STATUS_INDEX * 4);

	// Control register field positions
	localparam int          ENABLE_BIT  = 15;
	localparam int          SRC_HI      = 14;
	localparam int          SRC_LO      = 11;
	localparam int          FREQ_HI     = 10;
	localparam int          FREQ_LO     = 8;
	localparam int          SQL_HI      = 5;
	localparam int          SQL_LO      = 4;
	localparam int          PATH_HI     = 2;
	localparam int          PATH_LO     = 0;

	// Status register bit positions
	localparam int          ST_ACTIVE_BIT   = 0;
	localparam int          ST_PIN_BIT      = 1;
	localparam int          ST_RSVD_BIT     = 2;
	localparam int          ST_PASS_BIT     = 3;

	// Reset values
	localparam logic        ENABLE_RST  = 1'h0;
	localparam logic [3:0]  SRC_RST     = 4'h0;
	localparam logic [2:0]  FREQ_RST    = 3'h0;
	localparam logic [1:0]  SQL_RST     = 2'h0;
	localparam logic [2:0]  PATH_RST    = 3'h0;

	// Field codes
	localparam logic [3:0]  SRC_MAX     = 4'h3;
	localparam logic [2:0]  FREQ_25     = 3'h0;
	localparam logic [2:0]  FREQ_125    = 3'h1;
	localparam logic [2:0]  FREQ_31P25  = 3'h2;
	localparam logic [2:0]  PATH_SERIAL = 3'h0;
	localparam logic [2:0]  PATH_COPPER = 3'h1;
	localparam logic [2:0]  PATH_TXCLK  = 3'h2;
	localparam logic [1:0]  SQL_AUTO    = 2'h0;
	localparam logic [1:0]  SQL_RELAXED = 2'h1;
	localparam logic [1:0]  SQL_LINK    = 2'h2;
	localparam logic [1:0]  SQL_NONE    = 2'h3;

	// Reference ticks per output half period
	localparam logic [2:0]  HALF_125    = 3'h1;
	localparam logic [2:0]  HALF_31P25  = 3'h4;
	localparam logic [2:0]  HALF_25     = 3'h5;

	typedef enum logic [1:0] {
		SPEED_10   = 2'h0,
		SPEED_100  = 2'h1,
		SPEED_1000 = 2'h2
	} speed_e;

	// Link state of one port
	typedef struct packed {
		logic   link_up;
		logic   link_stable;
		speed_e speed;
		logic   master;
		logic   eee_on;
		logic   lp_idle_rx;
	} port_status_s;

	typedef struct packed {
		logic       enable;
		logic [3:0] src;
		logic [2:0] freq;
		logic [1:0] sql;
		logic [2:0] path;
	} ctrl_s;

	typedef enum logic [2:0] {
		OUT_OFF   = 3'b001,
		OUT_RUN   = 3'b010,
		OUT_DRAIN = 3'b100
	} out_state_e;

endpackage

// ---- logic/pin_sync3.sv ----
// Purpose: Three-stage synchroniser for an asynchronous pin
// Assumes: Pin level may change at any time
// Notes:   Output follows only when second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3
	import rclk_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output logic      level_out
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.level = st_r.s3;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.level;

endmodule
`default_nettype wire

// ---- logic/recovered_clock_output_select.sv ----
// Purpose: Recovered clock one output with source, path, rate and squelch control
// Assumes: Source ticks and port status come from logic on sys_clk
// Notes:   Output is a register; it only stops after a falling half period
//
// Functional notes
// - Control bit 15 enables the output; resets to 0, output off.
// - Bits 14:11 select source port 0..3; higher codes reserved; default 0.
// - Bits 10:8 select 25, 125 or 31.25 MHz; others reserved; default 0.
// - Squelch 00: low when link down, unstable, 1000 master/10M, or EEE 100/1000 slave.
// - Squelch 01: as 00 but 1000 master and 10M modes still pass.
// - Squelch 01 in EEE: clock also passes while LP idle is received.
// - Squelch 10: suppress only while link is down.
// - Squelch 11: no link-based squelch, clock passes even with link down.
// - External squelch pin high forces squelch regardless of settings.
// - Bits 2:0 pick serial, copper or transmitter clock; others reserved.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module recovered_clock_output_select
	import rclk_pkg::*;
(
	input  wire logic                                  sys_clk,
	input  wire logic                                  rst_b,
	input  wire logic [ADDR_W-1:0]                     avs_address,
	input  wire logic                                  avs_read,
	input  wire logic                                  avs_write,
	input  wire logic [DATA_W-1:0]                     avs_writedata,
	input  wire logic [3:0]                            avs_byteenable,
	output logic [DATA_W-1:0]                          avs_readdata,
	output logic                                       avs_waitrequest,
	input  wire logic [NUM_PORTS-1:0][NUM_PATHS-1:0]   src_tick,
	input  wire port_status_s [NUM_PORTS-1:0]          port_status,
	input  wire logic                                  squelch_pin,
	output logic                                       recovered_clock_one_output
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		ctrl_s             ctrl;
		logic              ack;
		logic [DATA_W-1:0] rdata;
		out_state_e        state;
		logic [2:0]        cnt;
		logic              clk_out;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	logic                 pin_squelch;
	logic [NUM_PORTS-1:0] port_pass;
	logic                 sel_pass;
	logic                 sel_tick;
	logic                 rsvd_code;
	logic                 gate;
	logic [2:0]           half_cnt;
	logic [2:0]           cnt_inc;
	logic                 toggle;
	logic                 req;
	logic                 hit_ctrl;
	logic                 hit_status;
	logic [CTRL_W-1:0]    ctrl_word;
	logic [CTRL_W-1:0]    ctrl_wr;
	logic [DATA_W-1:0]    status_word;

	////////////////////////////////////////////////////////////////////////
	// External squelch pin

	pin_sync3 u_squelch_sync (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.pin_in    (squelch_pin),
		.level_out (pin_squelch)
	);

	////////////////////////////////////////////////////////////////////////
	// Per-port squelch decision

	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			logic up_ok;
			logic no_rec_mode;
			logic eee_block;
			always_comb begin
				up_ok       = port_status[p].link_up & port_status[p].link_stable;
				no_rec_mode = (port_status[p].speed == SPEED_10) |
				              ((port_status[p].speed == SPEED_1000) & port_status[p].master);
				eee_block   = port_status[p].eee_on &
				              ((port_status[p].speed == SPEED_100) |
				               ((port_status[p].speed == SPEED_1000) & ~port_status[p].master));
				case (st_r.ctrl.sql)
					SQL_AUTO: begin
						port_pass[p] = up_ok & ~no_rec_mode & ~eee_block;
					end
					SQL_RELAXED: begin
						port_pass[p] = up_ok & ~(eee_block & ~port_status[p].lp_idle_rx);
					end
					SQL_LINK: begin
						port_pass[p] = port_status[p].link_up;
					end
					SQL_NONE: begin
						port_pass[p] = 1'h1;
					end
					default: begin
						port_pass[p] = 1'h0;
					end
				endcase
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Source, path and rate selection

	always_comb begin
		rsvd_code = 1'h0;
		sel_pass  = 1'h0;
		sel_tick  = 1'h0;
		half_cnt  = HALF_25;
		if (st_r.ctrl.src > SRC_MAX) begin
			rsvd_code = 1'h1;
		end else begin
			sel_pass = port_pass[st_r.ctrl.src[1:0]];
			case (st_r.ctrl.path)
				PATH_SERIAL: sel_tick = src_tick[st_r.ctrl.src[1:0]][0];
				PATH_COPPER: sel_tick = src_tick[st_r.ctrl.src[1:0]][1];
				PATH_TXCLK:  sel_tick = src_tick[st_r.ctrl.src[1:0]][2];
				default:     rsvd_code = 1'h1;
			endcase
		end
		case (st_r.ctrl.freq)
			FREQ_25:    half_cnt = HALF_25;
			FREQ_125:   half_cnt = HALF_125;
			FREQ_31P25: half_cnt = HALF_31P25;
			default:    rsvd_code = 1'h1;
		endcase
	end

	assign gate    = st_r.ctrl.enable & ~pin_squelch & sel_pass & ~rsvd_code;
	assign cnt_inc = st_r.cnt + 3'h1;
	assign toggle  = sel_tick & (cnt_inc >= half_cnt);

	////////////////////////////////////////////////////////////////////////
	// Register bus decode

	assign req        = avs_read | avs_write;
	assign hit_ctrl   = (avs_address == CTRL_ADDR);
	assign hit_status = (avs_address == STATUS_ADDR);

	always_comb begin
		ctrl_word                   = '0;
		ctrl_word[ENABLE_BIT]       = st_r.ctrl.enable;
		ctrl_word[SRC_HI:SRC_LO]    = st_r.ctrl.src;
		ctrl_word[FREQ_HI:FREQ_LO]  = st_r.ctrl.freq;
		ctrl_word[SQL_HI:SQL_LO]    = st_r.ctrl.sql;
		ctrl_word[PATH_HI:PATH_LO]  = st_r.ctrl.path;
		ctrl_wr                     = ctrl_word;
		if (avs_byteenable[0]) begin
			ctrl_wr[7:0] = avs_writedata[7:0];
		end
		if (avs_byteenable[1]) begin
			ctrl_wr[15:8] = avs_writedata[15:8];
		end
		status_word                = '0;
		status_word[ST_ACTIVE_BIT] = (st_r.state != OUT_OFF);
		status_word[ST_PIN_BIT]    = pin_squelch;
		status_word[ST_RSVD_BIT]   = rsvd_code;
		status_word[ST_PASS_BIT]   = sel_pass;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt     = st_r;
		st_nxt.ack = req & ~st_r.ack;
		if (req & ~st_r.ack) begin
			if (hit_ctrl) begin
				st_nxt.rdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl_word};
			end else if (hit_status) begin
				st_nxt.rdata = status_word;
			end else begin
				st_nxt.rdata = '0;
			end
		end
		if (avs_write & st_r.ack & hit_ctrl) begin
			st_nxt.ctrl.enable = ctrl_wr[ENABLE_BIT];
			st_nxt.ctrl.src    = ctrl_wr[SRC_HI:SRC_LO];
			st_nxt.ctrl.freq   = ctrl_wr[FREQ_HI:FREQ_LO];
			st_nxt.ctrl.sql    = ctrl_wr[SQL_HI:SQL_LO];
			st_nxt.ctrl.path   = ctrl_wr[PATH_HI:PATH_LO];
		end

		if (sel_tick) begin
			st_nxt.cnt = toggle ? 3'h0 : cnt_inc;
		end
		case (st_r.state)
			OUT_OFF: begin
				st_nxt.clk_out = 1'h0;
				st_nxt.cnt     = 3'h0;
				if (gate) begin
					st_nxt.state = OUT_RUN;
				end
			end
			OUT_RUN: begin
				if (!gate) begin
					st_nxt.state = st_r.clk_out ? OUT_DRAIN : OUT_OFF;
					st_nxt.cnt   = st_r.clk_out ? st_nxt.cnt : 3'h0;
				end else if (toggle) begin
					st_nxt.clk_out = ~st_r.clk_out;
				end
			end
			OUT_DRAIN: begin
				// Finish the high half before holding low
				if (toggle) begin
					st_nxt.clk_out = 1'h0;
					st_nxt.state   = gate ? OUT_RUN : OUT_OFF;
				end else if (gate) begin
					st_nxt.state = OUT_RUN;
				end
			end
			default: begin
				st_nxt.state   = OUT_OFF;
				st_nxt.clk_out = 1'h0;
				st_nxt.cnt     = 3'h0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r.ctrl.enable <= ENABLE_RST;
			st_r.ctrl.src    <= SRC_RST;
			st_r.ctrl.freq   <= FREQ_RST;
			st_r.ctrl.sql    <= SQL_RST;
			st_r.ctrl.path   <= PATH_RST;
			st_r.ack         <= 1'h0;
			st_r.rdata       <= '0;
			st_r.state       <= OUT_OFF;
			st_r.cnt         <= 3'h0;
			st_r.clk_out     <= 1'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata               = st_r.rdata;
	assign avs_waitrequest            = req & ~st_r.ack;
	assign recovered_clock_one_output = st_r.clk_out;

endmodule
`default_nettype wire

// ---- testbench/rclk_sink.sv ----
// Purpose: Timing circuit model that consumes the recovered clock
// Assumes: Output is sampled on the system clock
// Notes:   Counts rising edges seen on the clock input
`timescale 1ns/1ps
`default_nettype none
module rclk_sink (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic clk_in,
	output int        edges
);
	logic prev_r;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_r <= 1'b0;
			edges  <= 0;
		end else begin
			prev_r <= clk_in;
			if (clk_in && !prev_r) begin
				edges <= edges + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/rclk_sva.sv ----
// Purpose: Port checks for the recovered clock one output block
// Assumes: Ticks present on every cycle while squelch is tested
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module rclk_sva
	import rclk_pkg::*;
(
	input wire logic                                sys_clk,
	input wire logic                                rst_b,
	input wire logic [ADDR_W-1:0]                   avs_address,
	input wire logic                                avs_read,
	input wire logic                                avs_write,
	input wire logic [DATA_W-1:0]                   avs_readdata,
	input wire logic                                avs_waitrequest,
	input wire logic [NUM_PORTS-1:0][NUM_PATHS-1:0] src_tick,
	input wire logic                                squelch_pin,
	input wire logic                                recovered_clock_one_output
);
	logic       wrote_r;
	logic [3:0] sq_r;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrote_r <= 1'b0;
			sq_r    <= 4'h0;
		end else begin
			if (avs_write && !avs_waitrequest) begin
				wrote_r <= 1'b1;
			end
			sq_r <= (!squelch_pin || src_tick == '0) ? 4'h0 : (sq_r == 4'hF ? sq_r : sq_r + 4'h1);
		end
	end

	////////////////////////////////////////
	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_read_done;
		avs_read && !avs_waitrequest;
	endsequence

	AST_WAIT_ONE:
		assert property (s_req_wait |=> !avs_waitrequest) else $error("wait state longer than one");
	AST_IDLE_FREE:
		assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
	AST_UNMAPPED_ZERO:
		assert property (s_read_done and (avs_address != CTRL_ADDR && avs_address != STATUS_ADDR)
			|-> avs_readdata == '0) else $error("unmapped read not zero");
	AST_CTRL_RSVD_ZERO:
		assert property (s_read_done and (avs_address == CTRL_ADDR)
			|-> (avs_readdata & 32'hFFFF00C8) == '0) else $error("reserved control bits set");
	AST_RESET_QUIET:
		assert property ($rose(rst_b) |-> avs_readdata == '0 && !recovered_clock_one_output)
			else $error("outputs busy after reset");
	AST_OFF_AFTER_RESET:
		assert property (!wrote_r |-> !recovered_clock_one_output) else $error("clock before enable");
	AST_SQUELCH_PIN:
		assert property (sq_r >= 4'hC |-> !recovered_clock_one_output) else $error("pin squelch ignored");
	AST_TOGGLE_ON_TICK:
		assert property (!$stable(recovered_clock_one_output) |-> $past(|src_tick) || $past(|src_tick, 2))
			else $error("output moved without tick");
endmodule

bind recovered_clock_output_select rclk_sva u_sva (
	.sys_clk                   (sys_clk),
	.rst_b                     (rst_b),
	.avs_address               (avs_address),
	.avs_read                  (avs_read),
	.avs_write                 (avs_write),
	.avs_readdata              (avs_readdata),
	.avs_waitrequest           (avs_waitrequest),
	.src_tick                  (src_tick),
	.squelch_pin               (squelch_pin),
	.recovered_clock_one_output(recovered_clock_one_output)
);
`default_nettype wire

// ---- testbench/recovered_clock_output_select_tb_top.sv ----
// Purpose: Self-checking bench for the recovered clock one output
// Assumes: Ticks every cycle on the lines that are switched on
// Notes:   Edges counted over whole periods after settling
`timescale 1ns/1ps
`default_nettype none
module recovered_clock_output_select_tb_top
	import rclk_pkg::*;
;
	logic                                sys_clk = 0;
	logic                                rst_b = 0;
	logic [ADDR_W-1:0]                   avs_address = '0;
	logic                                avs_read = 0;
	logic                                avs_write = 0;
	logic [DATA_W-1:0]                   avs_writedata = '0;
	logic [DATA_W-1:0]                   avs_readdata;
	logic                                avs_waitrequest;
	logic [NUM_PORTS-1:0][NUM_PATHS-1:0] src_tick = '1;
	port_status_s [NUM_PORTS-1:0]        port_status = '0;
	logic                                squelch_pin = 0;
	logic                                clk_out;
	logic [DATA_W-1:0]                   q;
	int                                  edges;
	int                                  mismatches = 0;
	int                                  compares = 0;
	localparam logic [6:0]               ST_TAB [8] = '{7'h10, 7'h70, 7'h74, 7'h60, 7'h6A, 7'h6B, 7'h50, 7'h72};
	localparam logic [3:0]               EX_TAB [8] = '{4'h8, 4'hF, 4'hE, 4'hE, 4'hC, 4'hE, 4'hC, 4'hC};

	always #2.5 sys_clk = ~sys_clk;

	recovered_clock_output_select DUT (
		.sys_clk                   (sys_clk),
		.rst_b                     (rst_b),
		.avs_address               (avs_address),
		.avs_read                  (avs_read),
		.avs_write                 (avs_write),
		.avs_writedata             (avs_writedata),
		.avs_byteenable            (4'hF),
		.avs_readdata              (avs_readdata),
		.avs_waitrequest           (avs_waitrequest),
		.src_tick                  (src_tick),
		.port_status               (port_status),
		.squelch_pin               (squelch_pin),
		.recovered_clock_one_output(clk_out)
	);
	rclk_sink u_sink (.sys_clk(sys_clk), .rst_b(rst_b), .clk_in(clk_out), .edges(edges));

	////////////////////////////////////////
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= {16'h0000, d};
		avs_write     <= wr;
		avs_read      <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			mismatches++;
			results();
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic expect_edges(input int exp);
		int e0;
		repeat (20) @(posedge sys_clk);
		#1;
		e0 = edges;
		repeat (80) @(posedge sys_clk);
		#1;
		chk(DATA_W'(edges - e0), DATA_W'(exp));
	endtask

	task automatic results();
		if (mismatches == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	task automatic t_regs();
		bus(1'b0, CTRL_ADDR, 16'h0000);
		chk(q, 32'h00000000);
		expect_edges(0);
		bus(1'b1, CTRL_ADDR, 16'hFFFF);
		bus(1'b1, 8'h10, 16'h1234);
		bus(1'b0, 8'h10, 16'h0000);
		chk(q, 32'h00000000);
		bus(1'b0, CTRL_ADDR, 16'h0000);
		chk(q, 32'h0000FF37);
	endtask

	task automatic t_rate();
		logic [2:0] h [4];
		h = '{HALF_25, HALF_125, HALF_31P25, 3'h0};
		for (int f = 0; f < 4; f++) begin
			bus(1'b1, CTRL_ADDR, 16'h8030 | (16'(f) << 8));
			expect_edges(h[f] == 3'h0 ? 0 : 40 / h[f]);
		end
	endtask

	task automatic t_sel();
		logic [11:0] oh;
		for (int s = 0; s < 5; s++)
			for (int p = 0; p < 4; p++)
				for (int m = 0; m < 2; m++) begin
					oh = (s < 4 && p < 3) ? 12'h001 << (s * 3 + p) : 12'h000;
					@(posedge sys_clk);
					src_tick <= m ? ~oh : oh;
					bus(1'b1, CTRL_ADDR, 16'h8130 | (16'(s) << 11) | 16'(p));
					expect_edges((m == 0 && s < 4 && p < 3) ? 40 : 0);
				end
		@(posedge sys_clk);
		src_tick <= '1;
	endtask

	task automatic t_sql();
		for (int i = 0; i < 8; i++)
			for (int l = 0; l < 4; l++) begin
				@(posedge sys_clk);
				port_status <= {NUM_PORTS{port_status_s'(ST_TAB[i])}};
				bus(1'b1, CTRL_ADDR, 16'h8100 | (16'(l) << 4));
				expect_edges(EX_TAB[i][l] ? 40 : 0);
			end
	endtask

	task automatic t_pin();
		bus(1'b1, CTRL_ADDR, 16'h8030);
		@(posedge sys_clk);
		squelch_pin <= 1'b1;
		expect_edges(0);
		bus(1'b0, STATUS_ADDR, 16'h0000);
		chk(q, 32'h0000000A);
		@(posedge sys_clk);
		squelch_pin <= 1'b0;
		expect_edges(8);
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		t_rate();
		t_sel();
		t_sql();
		t_pin();
		results();
	end

	initial begin
		repeat (40000) @(posedge sys_clk);
		mismatches++;
		results();
	end
endmodule
`default_nettype wire
